//--- logic/flash_ctrl_consts.svh
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH
// special-function register addresses
`define PSC_ADDR        8'h8f
`define FTC_ADDR        8'hb6
// reset values
`define PSC_RESET       8'h00
`define FTC_RESET       8'h80
// program_store_control fields
`define PSC_SCRATCH_BIT 2
`define PSC_ERASE_BIT   1
`define PSC_WRITE_BIT   0
`define PSC_USED_MASK   8'h07
// flash_timing_control fields
`define FTC_ONESHOT_BIT 7
`define FTC_RDALW_BIT   6
`define FTC_GATE_BIT    0
`define FTC_USED_MASK   8'hc1
// array geometry
`define PAGE_ADDR_BITS  9
`define SCRATCH_MASK    16'h007f
`define ERASED_BYTE     8'hff
// sense amplifier one-shot hold time
`define ONESHOT_NS      50
`define CLK_PERIOD_NS   10
`define ONESHOT_CYCLES  ((`ONESHOT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- logic/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
    // operation handed to the flash array macro
    typedef enum logic [1:0] {
        OP_NONE,
        OP_PROGRAM,
        OP_ERASE
    } flash_op_type;

    // command word towards the array
    typedef struct packed {
        flash_op_type op;        // program or page erase
        logic         scratch;   // 1: scratchpad sector, 0: main array
        logic [15:0]  addr;      // byte address (erase: any byte in the page)
        logic [7:0]   data;      // byte to program, already merged with old value
    } flash_cmd_type;
endpackage : flash_ctrl_pkg

//--- logic/flash_program_erase_control.sv
`timescale 1ns/100ps
`include "flash_ctrl_consts.svh"
// Behaviour
// [RULE_01] one-shot timer drops sense amps after reads
// [RULE_02] read-always bit keeps flash in read
// [RULE_03] reserved timing bits read zero, write zero
// [RULE_04] software writes need the write gate bit
// [RULE_05] scratchpad bit steers software accesses
// [RULE_06] software keeps scratchpad addresses below 0x80
// [RULE_07] erase plus write enable erases page
// [RULE_08] erase ignores the supplied data byte
// [RULE_09] erase enable alone does nothing
// [RULE_10] write enable makes xdata write program
// [RULE_11] software erases before programming a byte
// [RULE_12] 512-byte pages, erase sets bytes to ff
// [RULE_13] programming only clears bits to zero
// [RULE_14] stall core and hold interrupts while busy
// [RULE_15] reset: one-shot on, all write controls off
module flash_program_erase_control (
    input  wire logic                         clk_in,
    input  wire logic                         rst_b_in,
    // special-function register port
    input  wire logic [7:0]                   sfr_addr_in,
    input  wire logic                         sfr_wr_in,
    input  wire logic [7:0]                   sfr_wdata_in,
    output logic      [7:0]                   sfr_rdata_out,
    // external-data write from the core
    input  wire logic                         xdata_wr_in,
    input  wire logic [15:0]                  xdata_addr_in,
    input  wire logic [7:0]                   xdata_wdata_in,
    output logic                              xram_wr_out,
    // code-space read from the core
    input  wire logic                         code_rd_in,
    input  wire logic [15:0]                  code_addr_in,
    output logic      [7:0]                   code_rdata_out,
    // flash array macro
    output logic                              flash_rd_out,
    output logic      [15:0]                  flash_rd_addr_out,
    output logic                              flash_rd_scratch_out,
    input  wire logic [7:0]                   flash_rdata_in,
    output logic                              flash_cmd_valid_out,
    output flash_ctrl_pkg::flash_cmd_type     flash_cmd_out,
    input  wire logic                         flash_done_in,
    output logic                              sense_amp_on_out,
    // core side effects
    output logic                              cpu_stall_out,
    output logic                              irq_hold_out
);
    import flash_ctrl_pkg::*;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_ISSUE,
        ST_BUSY
    } seq_state_type;

    localparam int unsigned OS_CYCLES = `ONESHOT_CYCLES;
    localparam logic [7:0]  OS_LOAD   = 8'(OS_CYCLES);

    logic [7:0]    psc_q, psc_d;          // program_store_control
    logic [7:0]    ftc_q, ftc_d;          // flash_timing_control
    seq_state_type st_q, st_d;            // write/erase sequencer
    flash_cmd_type cmd_q, cmd_d;          // command being built or run
    logic          cmd_vld_q, cmd_vld_d;  // one-cycle launch strobe
    logic [7:0]    os_q, os_d;            // one-shot countdown
    logic [7:0]    rdata_q, rdata_d;      // registered code read data
    logic          rd_pend_q, rd_pend_d;  // code read awaiting array data
    logic          xram_q, xram_d;        // registered xram write strobe
    logic [7:0]    sfr_rd_q, sfr_rd_d;    // registered sfr read data

    // decoded control bits
    logic scratch_sel;
    logic erase_en;
    logic prog_en;
    logic oneshot_en;
    logic read_always;
    logic write_gate;
    logic flash_wr_req;
    logic fetch_rd;

    always_comb begin
        scratch_sel = psc_q[`PSC_SCRATCH_BIT];
        erase_en    = psc_q[`PSC_ERASE_BIT];
        prog_en     = psc_q[`PSC_WRITE_BIT];
        oneshot_en  = ftc_q[`FTC_ONESHOT_BIT];
        read_always = ftc_q[`FTC_RDALW_BIT];
        write_gate  = ftc_q[`FTC_GATE_BIT];
        // write enable redirects the xdata write away from xram [RULE_10]
        // without the gate the redirected write is simply dropped [RULE_04]
        flash_wr_req = xdata_wr_in && prog_en && write_gate && (st_q == ST_IDLE);
    end

    // register file next state
    always_comb begin
        psc_d = psc_q;
        ftc_d = ftc_q;
        if (sfr_wr_in && sfr_addr_in == `PSC_ADDR) begin
            // unused upper bits never store
            psc_d = sfr_wdata_in & `PSC_USED_MASK;
        end else if (sfr_wr_in && sfr_addr_in == `FTC_ADDR) begin
            // reserved bits 5..1 are forced to zero [RULE_03]
            ftc_d = sfr_wdata_in & `FTC_USED_MASK;
        end
        // readback of either register, zero elsewhere
        if (sfr_addr_in == `PSC_ADDR) begin
            sfr_rd_d = psc_q;
        end else if (sfr_addr_in == `FTC_ADDR) begin
            sfr_rd_d = ftc_q; // reserved field reads zero [RULE_03]
        end else begin
            sfr_rd_d = 8'h00;
        end
    end

    // register file flops
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            psc_q    <= `PSC_RESET; // all write, erase, scratch off [RULE_15]
            ftc_q    <= `FTC_RESET; // one-shot on, gate closed [RULE_15]
            sfr_rd_q <= 8'h00;
        end else begin
            psc_q    <= psc_d;
            ftc_q    <= ftc_d;
            sfr_rd_q <= sfr_rd_d;
        end
    end

    // write/erase sequencer next state
    always_comb begin
        st_d      = st_q;
        cmd_d     = cmd_q;
        cmd_vld_d = 1'b0;
        fetch_rd  = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (flash_wr_req) begin
                    cmd_d.scratch = scratch_sel; // array picked by scratch bit [RULE_05]
                    // scratch accesses keep only the low 7 bits; higher is undefined [RULE_06]
                    cmd_d.addr = scratch_sel ? (xdata_addr_in & `SCRATCH_MASK)
                                             : xdata_addr_in;
                    if (erase_en) begin
                        // erase needs both bits, so erase alone never lands here [RULE_09]
                        cmd_d.op   = OP_ERASE;              // [RULE_07]
                        cmd_d.data = `ERASED_BYTE;          // written byte ignored [RULE_08]
                        cmd_vld_d  = 1'b1;
                        st_d       = ST_BUSY;
                    end else begin
                        // fetch old byte first so the program can only clear bits
                        cmd_d.op   = OP_PROGRAM;
                        cmd_d.data = xdata_wdata_in;
                        st_d       = ST_FETCH;
                    end
                end
            end
            ST_FETCH: begin
                fetch_rd = 1'b1;
                st_d     = ST_ISSUE;
            end
            ST_ISSUE: begin
                // merge with current contents: ones cannot be created [RULE_13]
                cmd_d.data = cmd_q.data & flash_rdata_in;
                cmd_vld_d  = 1'b1;
                st_d       = ST_BUSY;
            end
            ST_BUSY: begin
                // wait for the array's own timed cycle to finish
                if (flash_done_in && !cmd_vld_q) begin
                    st_d     = ST_IDLE;
                    cmd_d.op = OP_NONE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // sequencer flops
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            st_q      <= ST_IDLE;
            cmd_q     <= '0;
            cmd_vld_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            cmd_q     <= cmd_d;
            cmd_vld_q <= cmd_vld_d;
        end
    end

    // read path and sense amplifier timer next state
    always_comb begin
        rd_pend_d = code_rd_in && (st_q == ST_IDLE);
        rdata_d   = rd_pend_q ? flash_rdata_in : rdata_q;
        // plain xdata writes pass to xram only while write enable is clear
        xram_d    = xdata_wr_in && !prog_en;
        os_d      = os_q;
        if (!oneshot_en) begin
            os_d = 8'h00;                              // timer held off [RULE_01]
        end else if (code_rd_in || fetch_rd) begin
            os_d = OS_LOAD;                            // retrigger on every read [RULE_01]
        end else if (os_q != 8'h00) begin
            os_d = os_q - 8'h01;
        end
    end

    // read path flops
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rd_pend_q <= 1'b0;
            rdata_q   <= 8'h00;
            xram_q    <= 1'b0;
            os_q      <= 8'h00;
        end else begin
            rd_pend_q <= rd_pend_d;
            rdata_q   <= rdata_d;
            xram_q    <= xram_d;
            os_q      <= os_d;
        end
    end

    // output drive
    always_comb begin
        sfr_rdata_out        = sfr_rd_q;
        xram_wr_out          = xram_q;
        code_rdata_out       = rdata_q;
        flash_rd_out         = (code_rd_in && st_q == ST_IDLE) || fetch_rd;
        // software reads also follow the scratch bit [RULE_05]
        flash_rd_scratch_out = fetch_rd ? cmd_q.scratch : scratch_sel;
        flash_rd_addr_out    = fetch_rd ? cmd_q.addr
                             : (scratch_sel ? (code_addr_in & `SCRATCH_MASK) : code_addr_in);
        flash_cmd_valid_out  = cmd_vld_q;
        flash_cmd_out        = cmd_q;
        // read-always wins; with timer off amps never switch off [RULE_02] [RULE_01]
        sense_amp_on_out     = read_always || !oneshot_en || flash_rd_out || (os_q != 8'h00);
        // stall and hold interrupts from request until done [RULE_14]
        cpu_stall_out        = flash_wr_req || (st_q != ST_IDLE);
        irq_hold_out         = cpu_stall_out;
    end
endmodule : flash_program_erase_control

//--- tb/flash_array_model.sv
`timescale 1ns/100ps
// array stand-in: one-cycle read data, op done a fixed time after launch
module flash_array_model #(
    parameter int DONE_LAT = 4 // cycles from launch to done
) (
    input  wire logic        clk_in,
    input  wire logic        rd_in,
    input  wire logic [15:0] rd_addr_in,
    input  wire logic        cmd_valid_in,
    output logic      [7:0]  rdata_out,
    output logic             done_out
);
    int cnt = 0; // busy countdown
    initial rdata_out = 8'h00;
    initial done_out = 1'b0;
    // data pattern from address; idle bus toggles so stale data never looks valid
    always @(posedge clk_in) begin
        rdata_out <= rd_in ? (rd_addr_in[7:0] ^ 8'h3c) : ~rdata_out;
        done_out <= (cnt == 1);
        if (cmd_valid_in) cnt <= DONE_LAT;
        else if (cnt != 0) cnt <= cnt - 1;
    end
endmodule : flash_array_model

//--- tb/flash_program_erase_control_sva.sv
`timescale 1ns/100ps
`include "flash_ctrl_consts.svh"
module flash_program_erase_control_sva
    import flash_ctrl_pkg::*;
(
    input wire logic          clk_in,
    input wire logic          rst_b_in,
    input wire logic [7:0]    sfr_addr_in,
    input wire logic [7:0]    sfr_rdata_out,
    input wire logic          xdata_wr_in,
    input wire logic [7:0]    xdata_wdata_in,
    input wire logic          xram_wr_out,
    input wire logic          flash_rd_out,
    input wire logic [15:0]   flash_rd_addr_out,
    input wire logic          flash_rd_scratch_out,
    input wire logic [7:0]    flash_rdata_in,
    input wire logic          flash_cmd_valid_out,
    input wire flash_cmd_type flash_cmd_out,
    input wire logic          flash_done_in,
    input wire logic          sense_amp_on_out,
    input wire logic          cpu_stall_out,
    input wire logic          irq_hold_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // launches of each operation kind
    sequence erase_s; flash_cmd_valid_out && flash_cmd_out.op == OP_ERASE; endsequence
    sequence prog_s; flash_cmd_valid_out && flash_cmd_out.op == OP_PROGRAM; endsequence
    erase_fill_a: assert property (erase_s |-> flash_cmd_out.data == 8'hff &&
        $past(xdata_wr_in)) else $error("erase launch wrong");
    prog_merge_a: assert property (prog_s |-> flash_cmd_out.data ==
        ($past(xdata_wdata_in, 3) & $past(flash_rdata_in))) else $error("program data wrong");
    stall_launch_a: assert property (flash_cmd_valid_out |-> cpu_stall_out)
        else $error("no stall at launch");
    stall_free_a: assert property (flash_done_in && !flash_cmd_valid_out |=>
        !cpu_stall_out || xdata_wr_in) else $error("stall kept after done");
    irq_hold_a: assert property (flash_cmd_valid_out |=> irq_hold_out && cpu_stall_out)
        else $error("irq hold dropped after launch");
    oneshot_span_a: assert property (flash_rd_out |-> sense_amp_on_out [*5])
        else $error("sense amps dropped early");
    scratch_range_a: assert property (flash_rd_out && flash_rd_scratch_out |->
        flash_rd_addr_out[15:7] == 9'h000) else $error("scratch address out of range");
    xram_cause_a: assert property (xram_wr_out |-> $past(xdata_wr_in) &&
        !flash_cmd_valid_out) else $error("xram pulse without write");
    reserved_zero_a: assert property (sfr_addr_in == `FTC_ADDR |=>
        sfr_rdata_out[5:1] == 5'h00) else $error("reserved bits not zero");
endmodule : flash_program_erase_control_sva
bind flash_program_erase_control flash_program_erase_control_sva sva (.*);

//--- tb/flash_program_erase_control_tb_top.sv
`timescale 1ns/100ps
`include "flash_ctrl_consts.svh"
module flash_program_erase_control_tb_top;
    import flash_ctrl_pkg::*;
    logic          clk_in = 1'b0, rst_b_in = 1'b0, sfr_wr_in = 1'b0;
    logic          xdata_wr_in = 1'b0, code_rd_in = 1'b0;
    logic [7:0]    sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, xdata_wdata_in = 8'h00;
    logic [15:0]   xdata_addr_in = 16'h0000, code_addr_in = 16'h0000, flash_rd_addr_out;
    logic [7:0]    sfr_rdata_out, code_rdata_out, flash_rdata_in;
    logic          xram_wr_out, flash_rd_out, flash_rd_scratch_out, flash_cmd_valid_out;
    logic          flash_done_in, sense_amp_on_out, cpu_stall_out, irq_hold_out;
    flash_cmd_type flash_cmd_out, last_cmd;
    int            n_errors = 0, n_checks = 0, n_cmd = 0, n_xram = 0;
    logic [7:0]    ftv [3] = '{8'hc0, 8'h00, 8'h80}; // timing settings for sense test
    always #5 clk_in = ~clk_in;
    flash_program_erase_control uut (
        .clk_in               (clk_in),
        .rst_b_in             (rst_b_in),
        .sfr_addr_in          (sfr_addr_in),
        .sfr_wr_in            (sfr_wr_in),
        .sfr_wdata_in         (sfr_wdata_in),
        .sfr_rdata_out        (sfr_rdata_out),
        .xdata_wr_in          (xdata_wr_in),
        .xdata_addr_in        (xdata_addr_in),
        .xdata_wdata_in       (xdata_wdata_in),
        .xram_wr_out          (xram_wr_out),
        .code_rd_in           (code_rd_in),
        .code_addr_in         (code_addr_in),
        .code_rdata_out       (code_rdata_out),
        .flash_rd_out         (flash_rd_out),
        .flash_rd_addr_out    (flash_rd_addr_out),
        .flash_rd_scratch_out (flash_rd_scratch_out),
        .flash_rdata_in       (flash_rdata_in),
        .flash_cmd_valid_out  (flash_cmd_valid_out),
        .flash_cmd_out        (flash_cmd_out),
        .flash_done_in        (flash_done_in),
        .sense_amp_on_out     (sense_amp_on_out),
        .cpu_stall_out        (cpu_stall_out),
        .irq_hold_out         (irq_hold_out)
    );
    flash_array_model arr (.clk_in, .rd_in(flash_rd_out), .rd_addr_in(flash_rd_addr_out),
        .cmd_valid_in(flash_cmd_valid_out), .rdata_out(flash_rdata_in), .done_out(flash_done_in));
    // tally launches and xram pulses
    always @(posedge clk_in) begin
        if (flash_cmd_valid_out === 1'b1) begin
            last_cmd <= flash_cmd_out;
            n_cmd <= n_cmd + 1;
        end
        if (xram_wr_out === 1'b1) n_xram <= n_xram + 1;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(negedge clk_in);
        sfr_wr_in = 1'b0;
        // idle cycle so a following call never re-raises the strobe in the same step
        @(negedge clk_in);
    endtask : sfr_wr
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr_in = a;
        @(negedge clk_in);
        check("sfr_rdata", sfr_rdata_out, exp);
    endtask : sfr_rd
    // write strobe, then wait out any stall under a bound
    task automatic xwr(input logic [15:0] a, input logic [7:0] d);
        int i;
        xdata_addr_in = a;
        xdata_wdata_in = d;
        xdata_wr_in = 1'b1;
        @(negedge clk_in);
        xdata_wr_in = 1'b0;
        for (i = 0; i < 50 && cpu_stall_out !== 1'b0; i++) @(negedge clk_in);
        if (i == 50) begin
            check("stall end", cpu_stall_out, 1'b0);
            final_report();
        end
        @(negedge clk_in);
    endtask : xwr
    initial begin
        repeat (9) @(negedge clk_in);
        rst_b_in = 1'b1;
        sfr_rd(`PSC_ADDR, 8'h00);
        sfr_rd(`FTC_ADDR, 8'h80);
        sfr_rd(8'h55, 8'h00);
        sfr_wr(`PSC_ADDR, 8'hff);
        sfr_rd(`PSC_ADDR, 8'h07);
        sfr_wr(`PSC_ADDR, 8'h01);
        xwr(16'h0300, 8'h00);
        check("gated ops", n_cmd + n_xram, 0);
        sfr_wr(`PSC_ADDR, 8'h02);
        sfr_wr(`FTC_ADDR, 8'h81);
        sfr_rd(`FTC_ADDR, 8'h81);
        xwr(16'h0300, 8'h00);
        check("erase alone", {n_cmd[15:0], n_xram[15:0]}, 32'h0000_0001);
        sfr_wr(`PSC_ADDR, 8'h03);
        xwr(16'h0234, 8'ha5);
        check("erase cmd", last_cmd, {OP_ERASE, 1'b0, 16'h0234, 8'hff});
        sfr_wr(`PSC_ADDR, 8'h01);
        xwr(16'h0205, 8'hf0);
        check("program cmd", last_cmd, {OP_PROGRAM, 1'b0, 16'h0205, 8'h30});
        sfr_wr(`PSC_ADDR, 8'h07);
        xwr(16'h0011, 8'h5a);
        check("scratch erase", last_cmd, {OP_ERASE, 1'b1, 16'h0011, 8'hff});
        sfr_wr(`PSC_ADDR, 8'h05);
        xwr(16'h0011, 8'hff);
        check("scratch cmd", last_cmd, {OP_PROGRAM, 1'b1, 16'h0011, 8'h2d});
        sfr_wr(`PSC_ADDR, 8'h00);
        xwr(16'h0400, 8'h12);
        check("xram pulses", n_xram, 2);
        foreach (ftv[k]) begin
            sfr_wr(`FTC_ADDR, ftv[k]);
            repeat (8) @(negedge clk_in);
            check("sense amps", sense_amp_on_out, ftv[k] != 8'h80);
        end
        sfr_wr(`PSC_ADDR, 8'h04);
        code_addr_in = 16'h0042;
        code_rd_in = 1'b1;
        #1 check("read scratch", flash_rd_scratch_out, 1'b1);
        @(negedge clk_in);
        code_rd_in = 1'b0;
        @(negedge clk_in);
        check("code data", code_rdata_out, 8'h7e);
        check("sense hold", sense_amp_on_out, 1'b1);
        // mid-run reset with scratch still selected: controls must drop back
        rst_b_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_b_in = 1'b1;
        sfr_rd(`PSC_ADDR, 8'h00);
        check("sense after reset", sense_amp_on_out, 1'b0);
        final_report();
    end
endmodule : flash_program_erase_control_tb_top
